/* File: logic/bwl_axil_slave.sv */
module bwl_axil_slave (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [bwl_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [bwl_pkg::DATA_W-1:0] wdata,
   input wire logic [bwl_pkg::STRB_W-1:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [bwl_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [bwl_pkg::DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   bwl_reg_if.bus reg_port
);

   logic aw_held_reg;
   logic w_held_reg;
   logic [bwl_pkg::IDX_W-1:0] aw_idx_reg;
   logic [bwl_pkg::DATA_W-1:0] wdata_reg;
   logic [bwl_pkg::STRB_W-1:0] wstrb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [bwl_pkg::DATA_W-1:0] rdata_reg;
   logic wr_go;
   logic rd_go;

   // ------------------------------------------------------------
   // Handshakes
   // ------------------------------------------------------------
   // One write and one read in flight; new address waits for response
   assign awready = ce && !aw_held_reg && !bvalid_reg;
   assign wready = ce && !w_held_reg && !bvalid_reg;
   assign arready = ce && !rvalid_reg;
   assign wr_go = ce && aw_held_reg && w_held_reg && !bvalid_reg;
   assign rd_go = arvalid && arready;

   assign reg_port.wr_en = wr_go;
   assign reg_port.wr_idx = aw_idx_reg;
   assign reg_port.wr_data = wdata_reg;
   assign reg_port.wr_strb = wstrb_reg;
   assign reg_port.rd_en = rd_go;
   assign reg_port.rd_idx = araddr[bwl_pkg::ADDR_W-1:bwl_pkg::WORD_LSB];

   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign rvalid = rvalid_reg;
   assign rresp = rresp_reg;
   assign rdata = rdata_reg;

   // ------------------------------------------------------------
   // Write path
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         aw_idx_reg <= '0;
      end else if (wr_go) begin
         aw_held_reg <= 1'b0;
      end else if (awvalid && awready) begin
         aw_held_reg <= 1'b1;
         aw_idx_reg <= awaddr[bwl_pkg::ADDR_W-1:bwl_pkg::WORD_LSB];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_reg <= 1'b0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
      end else if (wr_go) begin
         w_held_reg <= 1'b0;
      end else if (wvalid && wready) begin
         w_held_reg <= 1'b1;
         wdata_reg <= wdata;
         wstrb_reg <= wstrb;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= bwl_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= reg_port.wr_ok ? bwl_pkg::RESP_OKAY : bwl_pkg::RESP_SLVERR;
      end else if (ce && bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rresp_reg <= bwl_pkg::RESP_OKAY;
         rdata_reg <= '0;
      end else if (rd_go) begin
         rvalid_reg <= 1'b1;
         rresp_reg <= reg_port.rd_ok ? bwl_pkg::RESP_OKAY : bwl_pkg::RESP_SLVERR;
         rdata_reg <= reg_port.rd_data;
      end else if (ce && rready) begin
         rvalid_reg <= 1'b0;
      end
   end

endmodule

/* File: logic/bwl_pkg.sv */
package bwl_pkg;

   // ------------------------------------------------------------
   // Bus geometry
   // ------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int IDX_W = 10;
   localparam int WORD_LSB = 2;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------
   // Register indices; byte address is four times the index
   // ------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_NP_BOTTOM = 10'h020;
   localparam logic [IDX_W-1:0] IDX_NP_TOP = 10'h022;
   localparam logic [IDX_W-1:0] IDX_PF_BOTTOM = 10'h024;
   localparam logic [IDX_W-1:0] IDX_PF_TOP = 10'h026;
   localparam logic [IDX_W-1:0] IDX_PF_BOTTOM_HIGH = 10'h028;
   localparam logic [IDX_W-1:0] IDX_PF_TOP_HIGH = 10'h02C;
   localparam logic [IDX_W-1:0] IDX_IO_BOTTOM_HIGH = 10'h030;
   localparam logic [IDX_W-1:0] IDX_IO_TOP_HIGH = 10'h032;
   localparam logic [IDX_W-1:0] IDX_INIT_CTRL = 10'h040;

   // ------------------------------------------------------------
   // Field layout
   // ------------------------------------------------------------
   localparam int WIN_LSB = 4;
   localparam int WIN_MSB = 15;
   localparam int WIN_W = 12;
   localparam int CAP_BIT = 0;
   localparam int LOW_W = 20;
   localparam int IO_HIGH_W = 16;
   localparam int INIT_PF_CAP_BIT = 0;
   localparam int INIT_IO_CAP_BIT = 1;
   localparam int INIT_LOCK_BIT = 31;

   localparam logic [LOW_W-1:0] LOW_ONES = 20'hF_FFFF;
   localparam logic [LOW_W-1:0] LOW_ZERO = 20'h0_0000;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [WIN_W-1:0] RST_BOTTOM = 12'hFFF;
   localparam logic [WIN_W-1:0] RST_TOP = 12'h000;
   localparam logic RST_PF_CAP = 1'b1;
   localparam logic RST_IO_CAP = 1'b1;
   localparam logic [31:0] RST_PF_BOTTOM_HIGH = 32'hFFFF_FFFF;
   localparam logic [31:0] RST_PF_TOP_HIGH = 32'h0000_0000;
   localparam logic [IO_HIGH_W-1:0] RST_IO_BOTTOM_HIGH = 16'hFFFF;
   localparam logic [IO_HIGH_W-1:0] RST_IO_TOP_HIGH = 16'h0000;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

endpackage

/* File: logic/bwl_reg_if.sv */
interface bwl_reg_if;
   logic wr_en;
   logic [bwl_pkg::IDX_W-1:0] wr_idx;
   logic [bwl_pkg::DATA_W-1:0] wr_data;
   logic [bwl_pkg::STRB_W-1:0] wr_strb;
   logic wr_ok;
   logic rd_en;
   logic [bwl_pkg::IDX_W-1:0] rd_idx;
   logic [bwl_pkg::DATA_W-1:0] rd_data;
   logic rd_ok;

   modport bus (
      output wr_en,
      output wr_idx,
      output wr_data,
      output wr_strb,
      input wr_ok,
      output rd_en,
      output rd_idx,
      input rd_data,
      input rd_ok
   );

   modport regs (
      input wr_en,
      input wr_idx,
      input wr_data,
      input wr_strb,
      output wr_ok,
      input rd_en,
      input rd_idx,
      output rd_data,
      output rd_ok
   );
endinterface

/* File: logic/bwl_window_cmp.sv */
module bwl_window_cmp #(
   parameter int W = 32
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [W-1:0] addr,
   input wire logic [W-1:0] bottom,
   input wire logic [W-1:0] top,
   output logic hit
);

   if (W < 1) begin : g_bad_width
      $error("Window width must be positive");
   end

   // Inclusive bounds; bottom above top gives no hit at all
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hit <= 1'b0;
      end else if (ce) begin
         hit <= (addr >= bottom) && (addr <= top);
      end
   end

endmodule

/* File: logic/bwl_window_regs.sv */
// Design decision made here: the AXI4-Lite register port.
module bwl_window_regs (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [bwl_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [bwl_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [bwl_pkg::STRB_W-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [bwl_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [bwl_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] nonprefetch_addr,
   input wire logic [63:0] prefetch_addr,
   output logic nonprefetch_hit,
   output logic prefetch_hit,
   output logic prefetch_wide,
   output logic io_wide,
   output logic [bwl_pkg::IO_HIGH_W-1:0] io_bottom_high,
   output logic [bwl_pkg::IO_HIGH_W-1:0] io_top_high
);

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (bwl_pkg::ADDR_W - bwl_pkg::WORD_LSB != bwl_pkg::IDX_W) begin : g_bad_addr
      $error("Bus address width does not match the register index width");
   end
   if (bwl_pkg::WIN_MSB - bwl_pkg::WIN_LSB + 1 != bwl_pkg::WIN_W) begin : g_bad_field
      $error("Window field layout is inconsistent");
   end

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   bwl_reg_if reg_bus ();

   logic [bwl_pkg::WIN_W-1:0] np_bottom_reg;
   logic [bwl_pkg::WIN_W-1:0] np_top_reg;
   logic [bwl_pkg::WIN_W-1:0] pf_bottom_reg;
   logic [bwl_pkg::WIN_W-1:0] pf_top_reg;
   logic [31:0] pf_bottom_high_reg;
   logic [31:0] pf_top_high_reg;
   logic [bwl_pkg::IO_HIGH_W-1:0] io_bottom_high_reg;
   logic [bwl_pkg::IO_HIGH_W-1:0] io_top_high_reg;
   logic pf_cap_reg;
   logic io_cap_reg;
   logic init_lock_reg;
   logic [bwl_pkg::IO_HIGH_W-1:0] io_bottom_high_out_reg;
   logic [bwl_pkg::IO_HIGH_W-1:0] io_top_high_out_reg;
   logic pf_wide_out_reg;
   logic io_wide_out_reg;

   logic [bwl_pkg::DATA_W-1:0] byte_mask;
   logic [bwl_pkg::DATA_W-1:0] wr_old;
   logic [bwl_pkg::DATA_W-1:0] wr_word;
   logic [bwl_pkg::DATA_W-1:0] rd_word;
   logic rd_known;
   logic wr_known;
   logic [31:0] pf_bottom_high_vis;
   logic [31:0] pf_top_high_vis;
   logic [bwl_pkg::IO_HIGH_W-1:0] io_bottom_high_vis;
   logic [bwl_pkg::IO_HIGH_W-1:0] io_top_high_vis;
   logic [31:0] np_bottom_addr;
   logic [31:0] np_top_addr;
   logic [63:0] pf_bottom_addr;
   logic [63:0] pf_top_addr;

   // ------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------
   bwl_axil_slave u_slave (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .awaddr(s_axi_awaddr),
      .awvalid(s_axi_awvalid),
      .awready(s_axi_awready),
      .wdata(s_axi_wdata),
      .wstrb(s_axi_wstrb),
      .wvalid(s_axi_wvalid),
      .wready(s_axi_wready),
      .bresp(s_axi_bresp),
      .bvalid(s_axi_bvalid),
      .bready(s_axi_bready),
      .araddr(s_axi_araddr),
      .arvalid(s_axi_arvalid),
      .arready(s_axi_arready),
      .rdata(s_axi_rdata),
      .rresp(s_axi_rresp),
      .rvalid(s_axi_rvalid),
      .rready(s_axi_rready),
      .reg_port(reg_bus.bus)
   );

   // ------------------------------------------------------------
   // Visible values of the capability-gated registers
   // ------------------------------------------------------------
   // Stored contents survive a cleared capability; only the view is zero
   assign pf_bottom_high_vis = pf_cap_reg ? pf_bottom_high_reg : bwl_pkg::ZERO_WORD;
   assign pf_top_high_vis = pf_cap_reg ? pf_top_high_reg : bwl_pkg::ZERO_WORD;
   assign io_bottom_high_vis = io_cap_reg ? io_bottom_high_reg : '0;
   assign io_top_high_vis = io_cap_reg ? io_top_high_reg : '0;

   // ------------------------------------------------------------
   // Read decode
   // ------------------------------------------------------------
   // Reserved bits come back as zero from every register
   function automatic logic [bwl_pkg::DATA_W-1:0] read_word(
      input logic [bwl_pkg::IDX_W-1:0] idx
   );
      logic [bwl_pkg::DATA_W-1:0] w;
      w = '0;
      unique case (idx)
         bwl_pkg::IDX_NP_BOTTOM: begin
            w[bwl_pkg::WIN_MSB:bwl_pkg::WIN_LSB] = np_bottom_reg;
         end
         bwl_pkg::IDX_NP_TOP: begin
            w[bwl_pkg::WIN_MSB:bwl_pkg::WIN_LSB] = np_top_reg;
         end
         bwl_pkg::IDX_PF_BOTTOM: begin
            w[bwl_pkg::WIN_MSB:bwl_pkg::WIN_LSB] = pf_bottom_reg;
            w[bwl_pkg::CAP_BIT] = pf_cap_reg;
         end
         bwl_pkg::IDX_PF_TOP: begin
            w[bwl_pkg::WIN_MSB:bwl_pkg::WIN_LSB] = pf_top_reg;
            w[bwl_pkg::CAP_BIT] = pf_cap_reg;
         end
         bwl_pkg::IDX_PF_BOTTOM_HIGH: begin
            w = pf_bottom_high_vis;
         end
         bwl_pkg::IDX_PF_TOP_HIGH: begin
            w = pf_top_high_vis;
         end
         bwl_pkg::IDX_IO_BOTTOM_HIGH: begin
            w[bwl_pkg::IO_HIGH_W-1:0] = io_bottom_high_vis;
         end
         bwl_pkg::IDX_IO_TOP_HIGH: begin
            w[bwl_pkg::IO_HIGH_W-1:0] = io_top_high_vis;
         end
         bwl_pkg::IDX_INIT_CTRL: begin
            w[bwl_pkg::INIT_PF_CAP_BIT] = pf_cap_reg;
            w[bwl_pkg::INIT_IO_CAP_BIT] = io_cap_reg;
            w[bwl_pkg::INIT_LOCK_BIT] = init_lock_reg;
         end
         default: begin
            w = '0;
         end
      endcase
      return w;
   endfunction

   function automatic logic known_idx(input logic [bwl_pkg::IDX_W-1:0] idx);
      return idx == bwl_pkg::IDX_NP_BOTTOM || idx == bwl_pkg::IDX_NP_TOP
         || idx == bwl_pkg::IDX_PF_BOTTOM || idx == bwl_pkg::IDX_PF_TOP
         || idx == bwl_pkg::IDX_PF_BOTTOM_HIGH || idx == bwl_pkg::IDX_PF_TOP_HIGH
         || idx == bwl_pkg::IDX_IO_BOTTOM_HIGH || idx == bwl_pkg::IDX_IO_TOP_HIGH
         || idx == bwl_pkg::IDX_INIT_CTRL;
   endfunction

   // Procedural, so a register change re-evaluates it, not only a new index
   always_comb rd_word = read_word(reg_bus.rd_idx);
   assign rd_known = known_idx(reg_bus.rd_idx);
   assign wr_known = known_idx(reg_bus.wr_idx);
   assign reg_bus.rd_data = rd_word;
   assign reg_bus.rd_ok = rd_known;
   assign reg_bus.wr_ok = wr_known;

   // ------------------------------------------------------------
   // Write merge by byte lanes
   // ------------------------------------------------------------
   for (genvar g = 0; g < bwl_pkg::STRB_W; g++) begin : g_lane
      assign byte_mask[8*g +: 8] = {8{reg_bus.wr_strb[g]}};
   end

   // Lanes not strobed keep the value currently seen by software
   always_comb wr_old = read_word(reg_bus.wr_idx);
   assign wr_word = (wr_old & ~byte_mask) | (reg_bus.wr_data & byte_mask);

   // ------------------------------------------------------------
   // Memory window registers
   // ------------------------------------------------------------
   // Only bits 15:4 are stored; bits 3:0 have no flops behind them
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         np_bottom_reg <= bwl_pkg::RST_BOTTOM;
      end else if (ce && reg_bus.wr_en && reg_bus.wr_idx == bwl_pkg::IDX_NP_BOTTOM) begin
         np_bottom_reg <= wr_word[bwl_pkg::WIN_MSB:bwl_pkg::WIN_LSB];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         np_top_reg <= bwl_pkg::RST_TOP;
      end else if (ce && reg_bus.wr_en && reg_bus.wr_idx == bwl_pkg::IDX_NP_TOP) begin
         np_top_reg <= wr_word[bwl_pkg::WIN_MSB:bwl_pkg::WIN_LSB];
      end
   end

   // Bit 0 here is capability and is not taken from ordinary writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pf_bottom_reg <= bwl_pkg::RST_BOTTOM;
      end else if (ce && reg_bus.wr_en && reg_bus.wr_idx == bwl_pkg::IDX_PF_BOTTOM) begin
         pf_bottom_reg <= wr_word[bwl_pkg::WIN_MSB:bwl_pkg::WIN_LSB];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pf_top_reg <= bwl_pkg::RST_TOP;
      end else if (ce && reg_bus.wr_en && reg_bus.wr_idx == bwl_pkg::IDX_PF_TOP) begin
         pf_top_reg <= wr_word[bwl_pkg::WIN_MSB:bwl_pkg::WIN_LSB];
      end
   end

   // ------------------------------------------------------------
   // Upper halves, writable only while their capability is set
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pf_bottom_high_reg <= bwl_pkg::RST_PF_BOTTOM_HIGH;
      end else if (ce && reg_bus.wr_en && pf_cap_reg
                   && reg_bus.wr_idx == bwl_pkg::IDX_PF_BOTTOM_HIGH) begin
         pf_bottom_high_reg <= wr_word;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pf_top_high_reg <= bwl_pkg::RST_PF_TOP_HIGH;
      end else if (ce && reg_bus.wr_en && pf_cap_reg
                   && reg_bus.wr_idx == bwl_pkg::IDX_PF_TOP_HIGH) begin
         pf_top_high_reg <= wr_word;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         io_bottom_high_reg <= bwl_pkg::RST_IO_BOTTOM_HIGH;
      end else if (ce && reg_bus.wr_en && io_cap_reg
                   && reg_bus.wr_idx == bwl_pkg::IDX_IO_BOTTOM_HIGH) begin
         io_bottom_high_reg <= wr_word[bwl_pkg::IO_HIGH_W-1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         io_top_high_reg <= bwl_pkg::RST_IO_TOP_HIGH;
      end else if (ce && reg_bus.wr_en && io_cap_reg
                   && reg_bus.wr_idx == bwl_pkg::IDX_IO_TOP_HIGH) begin
         io_top_high_reg <= wr_word[bwl_pkg::IO_HIGH_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // Capability bits and their lock
   // ------------------------------------------------------------
   // Firmware sets capabilities once, then locks; only reset unlocks
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pf_cap_reg <= bwl_pkg::RST_PF_CAP;
         io_cap_reg <= bwl_pkg::RST_IO_CAP;
      end else if (ce && reg_bus.wr_en && !init_lock_reg
                   && reg_bus.wr_idx == bwl_pkg::IDX_INIT_CTRL) begin
         pf_cap_reg <= wr_word[bwl_pkg::INIT_PF_CAP_BIT];
         io_cap_reg <= wr_word[bwl_pkg::INIT_IO_CAP_BIT];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         init_lock_reg <= 1'b0;
      end else if (ce && reg_bus.wr_en && !init_lock_reg
                   && reg_bus.wr_idx == bwl_pkg::IDX_INIT_CTRL) begin
         init_lock_reg <= wr_word[bwl_pkg::INIT_LOCK_BIT];
      end
   end

   // ------------------------------------------------------------
   // Window assembly and comparison
   // ------------------------------------------------------------
   assign np_bottom_addr = {np_bottom_reg, bwl_pkg::LOW_ZERO};
   assign np_top_addr = {np_top_reg, bwl_pkg::LOW_ONES};
   // Narrow mode uses zero upper halves, as software also sees them
   assign pf_bottom_addr = {pf_bottom_high_vis, pf_bottom_reg, bwl_pkg::LOW_ZERO};
   assign pf_top_addr = {pf_top_high_vis, pf_top_reg, bwl_pkg::LOW_ONES};

   bwl_window_cmp #(
      .W(32)
   ) u_np_cmp (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .addr(nonprefetch_addr),
      .bottom(np_bottom_addr),
      .top(np_top_addr),
      .hit(nonprefetch_hit)
   );

   bwl_window_cmp #(
      .W(64)
   ) u_pf_cmp (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .addr(prefetch_addr),
      .bottom(pf_bottom_addr),
      .top(pf_top_addr),
      .hit(prefetch_hit)
   );

   // ------------------------------------------------------------
   // Registered status outputs toward the I/O decoder
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         io_bottom_high_out_reg <= '0;
         io_top_high_out_reg <= '0;
         pf_wide_out_reg <= 1'b0;
         io_wide_out_reg <= 1'b0;
      end else if (ce) begin
         io_bottom_high_out_reg <= io_bottom_high_vis;
         io_top_high_out_reg <= io_top_high_vis;
         pf_wide_out_reg <= pf_cap_reg;
         io_wide_out_reg <= io_cap_reg;
      end
   end

   assign io_bottom_high = io_bottom_high_out_reg;
   assign io_top_high = io_top_high_out_reg;
   assign prefetch_wide = pf_wide_out_reg;
   assign io_wide = io_wide_out_reg;

endmodule

/* File: tb/bridge_window_limit_regs_tb.sv */
module bridge_window_limit_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 0, aresetn = 0, ce = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, nonprefetch_hit, prefetch_hit, prefetch_wide, io_wide;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [15:0] io_bottom_high, io_top_high;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, nonprefetch_addr = 0, lf = 32'h0001_7E02;
   logic [63:0] prefetch_addr = 0;
   logic [33:0] q [$];
   logic [31:0] ev [8];
   logic [11:0] ad [8] = '{12'h080, 12'h088, 12'h090, 12'h098,
      12'h0A0, 12'h0B0, 12'h0C0, 12'h0C8};
   logic [31:0] rv [8] = '{32'h0000_FFF0, 0, 32'h0000_FFF1, 1, '1, 0, 32'h0000_FFFF, 0};
   logic [31:0] ta [4] = '{32'h1230_0000, 32'h123F_FFFF, 32'h1240_0000, 32'h122F_FFFF};
   int fails = 0, checks_done = 0, cyc = 0;
   bwl_window_regs i_dut (.*);
   always #5 aclk = ~aclk;
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic ck(input logic [33:0] got, input logic [33:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Ready is held from request to answer, so it toggles only between transfers
   task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d,
         input logic [1:0] r = 2'h0);
      q.push_back({r, w ? 32'h0000_0000 : d});
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_arvalid <= !w;
      s_axi_bready <= w;
      s_axi_rready <= !w;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!(s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready));
   endtask
   always @(posedge aclk) begin
      if (s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready)
         ck(s_axi_bvalid ? {s_axi_bresp, 32'h0000_0000} : {s_axi_rresp, s_axi_rdata}, q.pop_front());
      if (++cyc == 1000) begin
         fails++;
         finish_test();
      end
   end
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 8; i++)
         xf(0, ad[i], rv[i]);
      xf(0, 12'h100, 32'h0000_0003);
      for (int i = 0; i < 8; i++) begin
         lf = nx(lf);
         ev[i] = lf & (i < 4 ? 32'h0000_FFF0 : i < 6 ? 32'hFFFF_FFFF : 32'h0000_FFFF);
         ev[i] = ev[i] | 32'(i == 2 || i == 3);
         xf(1, ad[i], lf);
         xf(0, ad[i], ev[i]);
      end
      // Hidden upper halves must keep their stored value while capability is clear
      xf(1, 12'h100, 32'h0000_0000);
      for (int i = 4; i < 8; i++) begin
         xf(1, ad[i], ~lf);
         xf(0, ad[i], 32'h0000_0000);
      end
      xf(1, 12'h100, 32'h8000_0003);
      for (int i = 0; i < 8; i++)
         xf(0, ad[i], ev[i]);
      xf(1, 12'h100, 32'h0000_0000);
      xf(0, 12'h100, 32'h8000_0003);
      xf(1, 12'h0FC, lf, 2'h2);
      xf(0, 12'h0FC, 32'h0000_0000, 2'h2);
      for (int i = 0; i < 6; i++)
         xf(1, ad[i], i < 4 ? 32'h0000_1230 : 32'h0000_0001);
      foreach (ta[i]) begin
         nonprefetch_addr <= ta[i];
         prefetch_addr <= {32'h0000_0001, ta[i]};
         repeat (2) @(posedge aclk);
         ck(34'(nonprefetch_hit), 34'(i < 2));
         ck(34'(prefetch_hit), 34'(i < 2));
      end
      // Enable low must freeze the hit although the address now lies inside
      ce <= 1'b0;
      nonprefetch_addr <= ta[0];
      repeat (3) @(posedge aclk);
      ck(34'(nonprefetch_hit), 34'(0));
      ce <= 1'b1;
      finish_test();
   end
endmodule
bind bwl_window_regs bwl_chk i_chk (.*);

/* File: tb/bwl_chk_sva.sv */
module bwl_chk (
   input logic aclk,
   input logic aresetn,
   input logic s_axi_awvalid,
   input logic s_axi_awready,
   input logic s_axi_wvalid,
   input logic s_axi_wready,
   input logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic s_axi_rvalid,
   input logic s_axi_rready,
   input logic prefetch_wide,
   input logic io_wide,
   input logic [15:0] io_bottom_high,
   input logic [15:0] io_top_high
);
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   reset_caps_a: assert property ($rose(aresetn) |-> ##[1:2] prefetch_wide && io_wide &&
      io_bottom_high == 16'hFFFF && io_top_high == '0) else $error("bad caps");
   io_hide_a: assert property (!io_wide |-> io_bottom_high == '0 && io_top_high == '0)
      else $error("io shown");
   b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("b");
   r_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("r");
   ar_blk_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar");
   aw_blk_a: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw");
   rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("rd");
   wr_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("wr");
   cover property (s_axi_bvalid);
   cover property (s_axi_rvalid);
   cover property (!io_wide ##1 io_wide);
endmodule
